// file: rtl/trx_regs.vh
`ifndef TRX_REGS_VH
`define TRX_REGS_VH

// instruction register width, capture pattern and reset value
`define TRX_IR_W        8
`define TRX_IR_CAPTURE  8'h3D
`define TRX_IR_RESET    8'hFF

// opcodes for the logic-side-only scan mode
`define TRX_M0_EXTEST   8'h00
`define TRX_M0_SAMPLE   8'h82
`define TRX_M0_CLAMP    8'h87
`define TRX_M0_HIGHZ    8'h06

// opcodes for the scan mode that includes the differential pins
`define TRX_M1_EXTEST   8'h99
`define TRX_M1_SAMPLE   8'h92
`define TRX_M1_CLAMP    8'h8F
`define TRX_M1_HIGHZ    8'h06

// boundary cell positions, bit 0 is nearest the test data output
`define TRX_CELL_DE     0
`define TRX_CELL_RE     1
`define TRX_CELL_CH0    2

// boundary cell reset value
`define TRX_BSR_RESET   1'b0

`endif

// file: rtl/trx_tap_fsm.v
`timescale 1ns/1ps
// sixteen-state test port controller, advanced on sampled clock rises
module trx_tap_fsm (
	input  wire sys_clk_in,   // system clock
	input  wire sys_rst_in,   // synchronous reset, active high
	input  wire tck_rise_in,  // one-cycle pulse on a test clock rise
	input  wire tms_in,       // synchronised mode select
	input  wire trst_n_in,    // synchronised test reset, active low
	output wire in_tlr_out,   // in test-logic-reset
	output wire in_cap_dr_out, // in capture-DR
	output wire in_sh_dr_out, // in shift-DR
	output wire in_up_dr_out, // in update-DR
	output wire in_cap_ir_out, // in capture-IR
	output wire in_sh_ir_out, // in shift-IR
	output wire in_up_ir_out  // in update-IR
);
	localparam [3:0] ST_TLR   = 4'hF;
	localparam [3:0] ST_RTI   = 4'hC;
	localparam [3:0] ST_SELDR = 4'h7;
	localparam [3:0] ST_CAPDR = 4'h6;
	localparam [3:0] ST_SHDR  = 4'h2;
	localparam [3:0] ST_EX1DR = 4'h1;
	localparam [3:0] ST_PADR  = 4'h3;
	localparam [3:0] ST_EX2DR = 4'h0;
	localparam [3:0] ST_UPDR  = 4'h5;
	localparam [3:0] ST_SELIR = 4'h4;
	localparam [3:0] ST_CAPIR = 4'hE;
	localparam [3:0] ST_SHIR  = 4'hA;
	localparam [3:0] ST_EX1IR = 4'h9;
	localparam [3:0] ST_PAIR  = 4'hB;
	localparam [3:0] ST_EX2IR = 4'h8;
	localparam [3:0] ST_UPIR  = 4'hD;

	reg [3:0] state_q;
	reg [3:0] state_d;

	// next state from the mode select level at a test clock rise
	always @* begin
		case (state_q)
		ST_TLR:   state_d = tms_in ? ST_TLR   : ST_RTI;
		ST_RTI:   state_d = tms_in ? ST_SELDR : ST_RTI;
		ST_SELDR: state_d = tms_in ? ST_SELIR : ST_CAPDR;
		ST_CAPDR: state_d = tms_in ? ST_EX1DR : ST_SHDR;
		ST_SHDR:  state_d = tms_in ? ST_EX1DR : ST_SHDR;
		ST_EX1DR: state_d = tms_in ? ST_UPDR  : ST_PADR;
		ST_PADR:  state_d = tms_in ? ST_EX2DR : ST_PADR;
		ST_EX2DR: state_d = tms_in ? ST_UPDR  : ST_SHDR;
		ST_UPDR:  state_d = tms_in ? ST_SELDR : ST_RTI;
		ST_SELIR: state_d = tms_in ? ST_TLR   : ST_CAPIR;
		ST_CAPIR: state_d = tms_in ? ST_EX1IR : ST_SHIR;
		ST_SHIR:  state_d = tms_in ? ST_EX1IR : ST_SHIR;
		ST_EX1IR: state_d = tms_in ? ST_UPIR  : ST_PAIR;
		ST_PAIR:  state_d = tms_in ? ST_EX2IR : ST_PAIR;
		ST_EX2IR: state_d = tms_in ? ST_UPIR  : ST_SHIR;
		ST_UPIR:  state_d = tms_in ? ST_SELDR : ST_RTI;
		default:  state_d = ST_TLR;
		endcase
	end

	// test reset forces test-logic-reset regardless of the test clock
	always @(posedge sys_clk_in) begin
		if (sys_rst_in || !trst_n_in) begin
			state_q <= ST_TLR;
		end else if (tck_rise_in) begin
			state_q <= state_d;
		end
	end

	// state flags for the data path
	assign in_tlr_out    = (state_q == ST_TLR);
	assign in_cap_dr_out = (state_q == ST_CAPDR);
	assign in_sh_dr_out  = (state_q == ST_SHDR);
	assign in_up_dr_out  = (state_q == ST_UPDR);
	assign in_cap_ir_out = (state_q == ST_CAPIR);
	assign in_sh_ir_out  = (state_q == ST_SHIR);
	assign in_up_ir_out  = (state_q == ST_UPIR);
endmodule // trx_tap_fsm

// file: rtl/trx_bscan_ctrl.v
`timescale 1ns/1ps
`include "trx_regs.vh"
module trx_bscan_ctrl #(
	parameter NCH = 9                          // transceiver channels
) (
	input  wire           sys_clk_in,          // system clock, 50 MHz
	input  wire           sys_rst_in,          // synchronous reset, high
	input  wire           line_drive_enable_in, // driver enable pin
	input  wire           listen_output_gate_n_in, // receiver gate, low on
	input  wire [NCH-1:0] drive_data_in,       // logic-side driver inputs
	input  wire [NCH-1:0] bus_true_sense_in,   // true bus pin level
	input  wire [NCH-1:0] bus_comp_sense_in,   // complement bus pin level
	output reg  [NCH-1:0] bus_true_out,        // true bus pin drive
	output reg  [NCH-1:0] bus_comp_out,        // complement bus pin drive
	output reg  [NCH-1:0] bus_oe_n_out,        // bus pin enable, low drives
	output reg  [NCH-1:0] rx_data_out,         // receiver outputs
	output reg  [NCH-1:0] rx_oe_n_out,         // receiver enable, low drives
	input  wire           scan_with_diff_pins_in, // scan mode strap
	input  wire           tck_in,              // test clock pin
	input  wire           tms_in,              // test mode select pin
	input  wire           tdi_in,              // test data in pin
	input  wire           trst_n_in,           // test reset pin, low
	output reg            tdo_out,             // test data out
	output reg            tdo_oe_n_out         // test data enable, low
);
	localparam L0   = `TRX_CELL_CH0 + 2 * NCH; // logic-side chain length
	localparam LMAX = `TRX_CELL_CH0 + 4 * NCH; // chain with bus pins
	localparam SW   = 7 + 3 * NCH;             // synchronised pin count

	// two-flop synchroniser for every pin input
	wire [SW-1:0] pin_raw;
	reg  [SW-1:0] pin_s1_q;
	reg  [SW-1:0] pin_s2_q;
	assign pin_raw = {bus_comp_sense_in, bus_true_sense_in, drive_data_in,
		scan_with_diff_pins_in, listen_output_gate_n_in,
		line_drive_enable_in, trst_n_in, tdi_in, tms_in, tck_in};
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pin_s1_q <= {SW{1'b0}};
			pin_s2_q <= {SW{1'b0}};
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
		end
	end

	wire           tck_s    = pin_s2_q[0];
	wire           tms_s    = pin_s2_q[1];
	wire           tdi_s    = pin_s2_q[2];
	wire           trst_n_s = pin_s2_q[3];
	wire           de_s     = pin_s2_q[4];
	wire           gate_n_s = pin_s2_q[5];
	wire           mode_s   = pin_s2_q[6];
	wire [NCH-1:0] din_s    = pin_s2_q[7 +: NCH];
	wire [NCH-1:0] true_s   = pin_s2_q[7 + NCH +: NCH];
	wire [NCH-1:0] comp_s   = pin_s2_q[7 + 2 * NCH +: NCH];

	// test clock edge detection on the synchronised level
	reg  tck_d_q;
	wire tck_rise = tck_s & ~tck_d_q;
	wire tck_fall = ~tck_s & tck_d_q;
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			tck_d_q <= 1'b0;
		end else begin
			tck_d_q <= tck_s;
		end
	end

	wire in_tlr;
	wire in_cap_dr;
	wire in_sh_dr;
	wire in_up_dr;
	wire in_cap_ir;
	wire in_sh_ir;
	wire in_up_ir;

	trx_tap_fsm u_tap (
		.sys_clk_in    (sys_clk_in),
		.sys_rst_in    (sys_rst_in),
		.tck_rise_in   (tck_rise),
		.tms_in        (tms_s),
		.trst_n_in     (trst_n_s),
		.in_tlr_out    (in_tlr),
		.in_cap_dr_out (in_cap_dr),
		.in_sh_dr_out  (in_sh_dr),
		.in_up_dr_out  (in_up_dr),
		.in_cap_ir_out (in_cap_ir),
		.in_sh_ir_out  (in_sh_ir),
		.in_up_ir_out  (in_up_ir)
	);

	// scan mode is latched only while the controller sits in reset
	reg mode_q;
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mode_q <= 1'b0;
		end else if (in_tlr) begin
			mode_q <= mode_s;
		end
	end

	// instruction shift stage and active instruction
	reg [`TRX_IR_W-1:0] ir_sh_q;
	reg [`TRX_IR_W-1:0] ir_q;

	// opcode decode, the map depends on the latched scan mode
	wire op_extest = mode_q ? (ir_q == `TRX_M1_EXTEST)
		: (ir_q == `TRX_M0_EXTEST);
	wire op_sample = mode_q ? (ir_q == `TRX_M1_SAMPLE)
		: (ir_q == `TRX_M0_SAMPLE);
	wire op_clamp  = mode_q ? (ir_q == `TRX_M1_CLAMP)
		: (ir_q == `TRX_M0_CLAMP);
	wire op_highz  = mode_q ? (ir_q == `TRX_M1_HIGHZ)
		: (ir_q == `TRX_M0_HIGHZ);
	wire sel_bsr   = op_extest | op_sample;
	wire test_out  = op_extest | op_clamp;

	// receiver state, held while the differential input is ambiguous
	reg [NCH-1:0] rx_q;
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rx_q <= {NCH{1'b0}};
		end else begin
			rx_q <= (true_s & ~comp_s) | (rx_q & ~(true_s ^ comp_s));
		end
	end

	// boundary register: shift stage, update stage and capture values
	reg  [LMAX-1:0] bsr_q;
	reg  [LMAX-1:0] upd_q;
	wire [LMAX-1:0] bsr_cap;
	wire [LMAX-1:0] bsr_shift;
	wire [NCH-1:0]  pair_ok = true_s ^ comp_s;

	assign bsr_cap[`TRX_CELL_DE] = de_s;
	assign bsr_cap[`TRX_CELL_RE] = gate_n_s;

	genvar gi;
	generate
		// logic-side cells then bus pin cells for each channel
		for (gi = 0; gi < NCH; gi = gi + 1) begin : g_cap
			assign bsr_cap[`TRX_CELL_CH0 + 2 * gi]     = din_s[gi];
			assign bsr_cap[`TRX_CELL_CH0 + 2 * gi + 1] = rx_q[gi];
			// non-complementary pairs are captured as zero
			assign bsr_cap[L0 + 2 * gi]     = true_s[gi] & pair_ok[gi];
			assign bsr_cap[L0 + 2 * gi + 1] = comp_s[gi] & pair_ok[gi];
		end
		// each stage takes its upper neighbour, the chain end takes data in
		for (gi = 0; gi < LMAX; gi = gi + 1) begin : g_shift
			if (gi == L0 - 1) begin : g_end0
				assign bsr_shift[gi] = mode_q ? bsr_q[gi + 1] : tdi_s;
			end else if (gi == LMAX - 1) begin : g_end1
				assign bsr_shift[gi] = tdi_s;
			end else begin : g_mid
				assign bsr_shift[gi] = bsr_q[gi + 1];
			end
		end
	endgenerate

	// data register capture, shift and update
	reg byp_q;
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			bsr_q <= {LMAX{`TRX_BSR_RESET}};
			upd_q <= {LMAX{`TRX_BSR_RESET}};
			byp_q <= 1'b0;
		end else begin
			if (tck_rise && in_cap_dr) begin
				byp_q <= 1'b0;
				if (sel_bsr) begin
					bsr_q <= bsr_cap;
				end
			end else if (tck_rise && in_sh_dr) begin
				byp_q <= tdi_s;
				if (sel_bsr) begin
					bsr_q <= bsr_shift;
				end
			end
			if (in_tlr) begin
				upd_q <= {LMAX{`TRX_BSR_RESET}};
			end else if (tck_fall && in_up_dr && sel_bsr) begin
				upd_q <= bsr_q;
			end
		end
	end

	// instruction capture, shift and update
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ir_sh_q <= `TRX_IR_RESET;
			ir_q    <= `TRX_IR_RESET;
		end else begin
			if (tck_rise && in_cap_ir) begin
				ir_sh_q <= `TRX_IR_CAPTURE;
			end else if (tck_rise && in_sh_ir) begin
				ir_sh_q <= {tdi_s, ir_sh_q[`TRX_IR_W-1:1]};
			end
			if (in_tlr) begin
				ir_q <= `TRX_IR_RESET; // bypass after test reset
			end else if (tck_fall && in_up_ir) begin
				ir_q <= ir_sh_q;
			end
		end
	end

	// test data out changes on the falling test clock edge
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			tdo_out      <= 1'b0;
			tdo_oe_n_out <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n_out <= ~(in_sh_ir | in_sh_dr);
			if (in_sh_ir) begin
				tdo_out <= ir_sh_q[0];
			end else if (in_sh_dr) begin
				tdo_out <= sel_bsr ? bsr_q[0] : byp_q;
			end
		end
	end

	// effective enables and data, system pins or update cells
	wire           de_e  = test_out ? upd_q[`TRX_CELL_DE] : de_s;
	wire           gte_e = test_out ? upd_q[`TRX_CELL_RE] : gate_n_s;
	wire [NCH-1:0] din_e;
	wire [NCH-1:0] rx_e;
	wire [NCH-1:0] tru_e;
	wire [NCH-1:0] cmp_e;
	generate
		for (gi = 0; gi < NCH; gi = gi + 1) begin : g_out
			assign din_e[gi] = test_out ? upd_q[`TRX_CELL_CH0 + 2 * gi] : din_s[gi];
			assign rx_e[gi]  = test_out ? upd_q[`TRX_CELL_CH0 + 2 * gi + 1] : rx_q[gi];
			// full mode drives the bus pins straight from their own cells
			assign tru_e[gi] = (test_out && mode_q) ? upd_q[L0 + 2 * gi]
				: din_e[gi];
			assign cmp_e[gi] = (test_out && mode_q) ? upd_q[L0 + 2 * gi + 1]
				: ~din_e[gi];
		end
	endgenerate

	// registered pin outputs, highz floats everything
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			bus_true_out <= {NCH{1'b0}};
			bus_comp_out <= {NCH{1'b0}};
			bus_oe_n_out <= {NCH{1'b1}};
			rx_data_out  <= {NCH{1'b0}};
			rx_oe_n_out  <= {NCH{1'b1}};
		end else begin
			bus_true_out <= tru_e;
			bus_comp_out <= cmp_e;
			bus_oe_n_out <= {NCH{~de_e | op_highz}};
			rx_data_out  <= rx_e;
			rx_oe_n_out  <= {NCH{gte_e | op_highz}};
		end
	end
endmodule // trx_bscan_ctrl

// file: tb/trx_bscan_ctrl_asserts.sv
`timescale 1ns/1ps
module trx_bscan_ctrl_asserts #(
	parameter NCH = 9 // transceiver channels
) (
	input wire logic           sys_clk_in,              // system clock
	input wire logic           sys_rst_in,              // sync reset
	input wire logic           line_drive_enable_in,    // driver enable
	input wire logic           listen_output_gate_n_in, // receiver gate
	input wire logic [NCH-1:0] drive_data_in,           // driver data
	input wire logic [NCH-1:0] bus_true_sense_in,       // true pin level
	input wire logic [NCH-1:0] bus_comp_sense_in,       // comp pin level
	input wire logic [NCH-1:0] bus_true_out,            // true pin drive
	input wire logic [NCH-1:0] bus_comp_out,            // comp pin drive
	input wire logic [NCH-1:0] bus_oe_n_out,            // bus enable
	input wire logic [NCH-1:0] rx_data_out,             // receiver data
	input wire logic [NCH-1:0] rx_oe_n_out,             // receiver enable
	input wire logic           tck_in,                  // test clock
	input wire logic           trst_n_in,               // test reset
	input wire logic           tdo_out,                 // test data out
	input wire logic           tdo_oe_n_out             // test data enable
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic [3:0] quiet_q; // cycles with test reset held low
	logic       norm;
	// functional path owns the outputs once test reset has held a while
	always @(posedge sys_clk_in) begin
		if (sys_rst_in || trst_n_in) quiet_q <= 4'h0;
		else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
	end
	assign norm = (quiet_q >= 4'h8);
	// driver outputs trail the pins by three clocks
	a_drv_true_data: assert property (
		norm && $past(line_drive_enable_in, 3)
		|-> bus_true_out == $past(drive_data_in, 3))
		else $error("true pin wrong");
	a_drv_comp_inv: assert property (
		norm && $past(line_drive_enable_in, 3)
		|-> bus_comp_out == ~$past(drive_data_in, 3))
		else $error("comp pin wrong");
	a_bus_oe_decode: assert property (
		norm |-> bus_oe_n_out == {NCH{~$past(line_drive_enable_in, 3)}})
		else $error("bus enable wrong");
	a_rx_oe_decode: assert property (
		norm |-> rx_oe_n_out == {NCH{$past(listen_output_gate_n_in, 3)}})
		else $error("rx enable wrong");
	// the receiver holds one more register, so it trails by four clocks
	a_rx_follows_sign: assert property (
		norm && !$past(listen_output_gate_n_in, 4)
		|-> ((rx_data_out ^ $past(bus_true_sense_in, 4))
		& ($past(bus_true_sense_in, 4) ^ $past(bus_comp_sense_in, 4)))
		== '0)
		else $error("rx data wrong");
	a_tdo_idle_tlr: assert property (
		norm |-> tdo_oe_n_out)
		else $error("tdo driven in reset");
	a_tdo_after_fall: assert property (
		$changed(tdo_out) && trst_n_in && $past(trst_n_in, 4)
		|-> !$past(tck_in, 1) && !$past(tck_in, 2))
		else $error("tdo moved off fall");
	a_reset_quiet: assert property (
		$fell(sys_rst_in) |-> bus_oe_n_out == {NCH{1'b1}}
		&& rx_oe_n_out == {NCH{1'b1}} && tdo_oe_n_out)
		else $error("outputs driven at reset");
	c_driver: cover property (norm && bus_oe_n_out == '0 && rx_oe_n_out != '0);
	c_loopback: cover property (norm && bus_oe_n_out == '0 && rx_oe_n_out == '0);
	c_shift: cover property (!tdo_oe_n_out);
endmodule // trx_bscan_ctrl_asserts

bind trx_bscan_ctrl trx_bscan_ctrl_asserts #(.NCH(NCH)) u_chk (
	.sys_clk_in              (sys_clk_in),
	.sys_rst_in              (sys_rst_in),
	.line_drive_enable_in    (line_drive_enable_in),
	.listen_output_gate_n_in (listen_output_gate_n_in),
	.drive_data_in           (drive_data_in),
	.bus_true_sense_in       (bus_true_sense_in),
	.bus_comp_sense_in       (bus_comp_sense_in),
	.bus_true_out            (bus_true_out),
	.bus_comp_out            (bus_comp_out),
	.bus_oe_n_out            (bus_oe_n_out),
	.rx_data_out             (rx_data_out),
	.rx_oe_n_out             (rx_oe_n_out),
	.tck_in                  (tck_in),
	.trst_n_in               (trst_n_in),
	.tdo_out                 (tdo_out),
	.tdo_oe_n_out            (tdo_oe_n_out)
);

// file: tb/trx_jtag_host.sv
`timescale 1ns/1ps
// test controller on the far side, test clock still between frames
module trx_jtag_host (
	output logic      tck_out,    // test clock
	output logic      tms_out,    // mode select
	output logic      tdi_out,    // data to device
	output logic      trst_n_out, // test reset, low
	input  wire logic tdo_in      // resolved data pin
);
	initial begin
		{tck_out, tms_out, tdi_out, trst_n_out} = 4'h6;
	end
	// one test clock, lines set while low, data sampled at the rise
	task automatic step(input logic m, d, output logic o);
		tms_out = m;
		tdi_out = d;
		#80 tck_out = 1'b1;
		o = tdo_in;
		#80 tck_out = 1'b0;
	endtask
	// release or pulse test reset, then park in run-test-idle
	task automatic tap_up(input logic pulse);
		logic x;
		if (pulse) begin
			trst_n_out = 1'b0;
			#320;
		end
		trst_n_out = 1'b1;
		step(1'b0, 1'b1, x);
	endtask
	// full scan from and back to run-test-idle
	task automatic scan(input logic ir, input int n, input logic [63:0] di,
		output logic [63:0] dq);
		logic x;
		int   i;
		dq = '0;
		step(1'b1, 1'b1, x);
		if (ir) step(1'b1, 1'b1, x);
		step(1'b0, 1'b1, x);
		step(1'b0, 1'b1, x);
		for (i = 0; i < n; i++) step(i == n - 1, di[i], dq[i]);
		step(1'b1, 1'b1, x);
		step(1'b0, 1'b1, x);
	endtask
endmodule // trx_jtag_host

// file: tb/trx_bscan_ctrl_test.sv
`timescale 1ns/1ps
module trx_bscan_ctrl_test;
	logic       clk, rst, de, gn, strap;
	logic [8:0] din, ts, cs;
	wire  [8:0] btru, bcmp, boe, rxd, rxoe;
	wire        tck, tms, tdi, trst_n, tdo, tdo_oe_n;
	int         errors, n_compared;
	initial begin
		{clk, rst, de, gn, strap, din, ts, cs} = {5'h08, 27'h0};
		forever #10 clk = ~clk;
	end
	trx_bscan_ctrl dut (.sys_clk_in(clk), .sys_rst_in(rst),
		.line_drive_enable_in(de), .listen_output_gate_n_in(gn),
		.drive_data_in(din), .bus_true_sense_in(ts), .bus_comp_sense_in(cs),
		.bus_true_out(btru), .bus_comp_out(bcmp), .bus_oe_n_out(boe),
		.rx_data_out(rxd), .rx_oe_n_out(rxoe), .scan_with_diff_pins_in(strap),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n),
		.tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n));
	trx_jtag_host host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.trst_n_out(trst_n), .tdo_in(tdo_oe_n ? 1'b1 : tdo));
	task automatic chk(input string what, input logic [63:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic pins(input logic [1:0] eg, input logic [8:0] d, t, c);
		@(negedge clk);
		{de, gn, din, ts, cs} = {eg, d, t, c};
		// the receiver path holds one more register than the driver path
		repeat (4) @(negedge clk);
	endtask
	task automatic ir(input logic [7:0] code, output logic [63:0] o);
		@(negedge clk);
		host.scan(1'b1, 8, {56'h0, code}, o);
		repeat (4) @(negedge clk);
	endtask
	task automatic dr(input int n, input logic [63:0] d, output logic [63:0] o);
		@(negedge clk);
		host.scan(1'b0, n, d, o);
		repeat (4) @(negedge clk);
	endtask
	function automatic logic [63:0] chain(input logic a, b,
		input logic [8:0] d, r, t, c);
		chain = {62'h0, b, a};
		for (int k = 0; k < 9; k++) begin
			{chain[3+2*k], chain[2+2*k]} = {r[k], d[k]};
			{chain[21+2*k], chain[20+2*k]} = {c[k], t[k]};
		end
	endfunction
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			pins(m[1:0], 9'h1A5, 9'h0F3, 9'h10C);
			chk("bus_oe_n", {9{~m[1]}}, boe);
			chk("rx_oe_n", {9{m[0]}}, rxoe);
			if (m[1]) chk("bus_true", 9'h1A5, btru);
			if (m[1]) chk("bus_comp", 9'h05A, bcmp);
			if (!m[0]) chk("rx_data", 9'h0F3, rxd);
		end
		pins(2'b00, 9'h1A5, 9'h1FF, 9'h0FF);
		chk("rx hold", 9'h1F3, rxd);
		$display("test modes done");
	endtask
	task automatic t_bypass;
		logic [63:0] o;
		host.tap_up(1'b0);
		ir(8'hFF, o);
		chk("ir capture", 64'h3D, o);
		dr(8, 64'hA5, o);
		chk("bypass", 64'h4A, o);
		ir(8'h55, o);
		dr(8, 64'hA5, o);
		chk("bypass other", 64'h4A, o);
		$display("test bypass done");
	endtask
	task automatic t_drive(input string what);
		chk(what, {9'h0C3, 9'h13C, 9'h0, 9'h1FF, 9'h0}, {btru, bcmp, boe, rxoe, rxd});
	endtask
	task automatic t_scan(input logic m);
		logic [63:0] o, msk, e;
		msk = m ? 64'h3F_FFFF_FFFF : 64'hF_FFFF;
		pins(2'b10, 9'h1A5, 9'h0F3, m ? 9'h10D : 9'h10C);
		ir(m ? 8'h92 : 8'h82, o);
		dr(m ? 38 : 20, 64'h0, o);
		e = chain(1, 0, 9'h1A5, 9'h0F3, 9'h0F2, 9'h10C) & msk;
		chk("sample", e, o);
		ir(m ? 8'h99 : 8'h00, o);
		// full mode must drive the bus from its own cells, not from din
		e = chain(1, 1, m ? 9'h111 : 9'h0C3, 9'h0, 9'h0C3, 9'h13C);
		dr(m ? 38 : 20, e, o);
		t_drive("extest");
		ir(m ? 8'h8F : 8'h87, o);
		t_drive("clamp");
		ir(8'h06, o);
		chk("highz", {9'h1FF, 9'h1FF}, {boe, rxoe});
		// the other mode's sample code must fall back to bypass
		ir(m ? 8'h82 : 8'h92, o);
		dr(8, 64'hA5, o);
		chk("cross map", 64'h4A, o);
		$display("test scan mode %0d done", m);
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// watchdog well past the expected run time
	initial begin
		#800000;
		errors++;
		final_report();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		t_modes();
		t_bypass();
		t_scan(1'b0);
		strap = 1'b1;
		host.tap_up(1'b1);
		t_scan(1'b1);
		final_report();
	end
endmodule // trx_bscan_ctrl_test
